/* design/rbt_pkg.sv */
// package for the registered bus transceiver: widths, register map and reset values
// assumes a single clock domain and an AXI4-Lite master on the register side
package rbt_pkg;
    localparam int          DATA_W      = 18;
    localparam int          FIFO_DEPTH  = 4;
    localparam int          AXI_AW      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_AB_HOLD = 8'h08;
    localparam logic [7:0]  OFS_BA_HOLD = 8'h0C;
    localparam int          CTRL_AB_LE  = 0;
    localparam int          CTRL_AB_CK  = 1;
    localparam int          CTRL_AB_CG  = 2;
    localparam int          CTRL_AB_OE  = 3;
    localparam int          CTRL_BA_LE  = 4;
    localparam int          CTRL_BA_CK  = 5;
    localparam int          CTRL_BA_CG  = 6;
    localparam int          CTRL_BA_OE  = 7;
    localparam logic [7:0]  CTRL_RESET  = 8'hCC;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage

/* design/rbt_fifo_if.sv */
// valid/ready carrier for one word stream between the block's own modules
interface rbt_fifo_if #(parameter int W = 18);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* design/rbt_fifo.sv */
// synchronous FIFO, width and depth parameters; read data taken combinationally from the array
// assumes one clock, synchronous active-low reset
module rbt_fifo #(
    parameter int W = 18,
    parameter int D = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    rbt_fifo_if.snk   wr,
    rbt_fifo_if.src   rd
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wPtr_r, wPtr_nxt, rPtr_r, rPtr_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    assign wr.ready = (cnt_r != AW'(0) + (AW+1)'(D)) ? 1'b1 : 1'b0;
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem[rPtr_r];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb begin
        wPtr_nxt = push ? ((wPtr_r == AW'(D-1)) ? '0 : wPtr_r + AW'(1)) : wPtr_r;
        rPtr_nxt = pop  ? ((rPtr_r == AW'(D-1)) ? '0 : rPtr_r + AW'(1)) : rPtr_r;
        cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wPtr_r <= '0;
            rPtr_r <= '0;
            cnt_r  <= '0;
        end else begin
            wPtr_r <= wPtr_nxt;
            rPtr_r <= rPtr_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wPtr_r] <= wr.data;
        end
    end
endmodule // rbt_fifo

/* design/rbt_path.sv */
// one transfer direction: transparent latch, held value, gated falling-edge capture
// assumes control inputs are synchronous samples of the direction's pins
module rbt_path #(
    parameter int W = 18
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] srcIn,
    input  wire logic         latchEnable,
    input  wire logic         captureClock,
    input  wire logic         clockGate,
    input  wire logic         driveEnable_n,
    output logic      [W-1:0] dstOut,
    output logic              dstOe,
    output logic      [W-1:0] held,
    output logic              capturePulse
);
    logic [W-1:0] store_r, store_nxt;
    logic         ckPrev_r;
    logic         fallEdge;

    assign fallEdge     = ckPrev_r && !captureClock;
    // capture only with the clock gate active low
    assign capturePulse = fallEdge && !latchEnable && !clockGate; // [R5] [R8] [R11]

    always_comb begin
        store_nxt = store_r; // [R4]
        if (latchEnable) begin
            store_nxt = srcIn;
        end else if (capturePulse) begin
            store_nxt = srcIn;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            store_r  <= '0;
            ckPrev_r <= 1'b0;
        end else begin
            store_r  <= store_nxt;
            ckPrev_r <= captureClock;
        end
    end

    // transparent mode bypasses the store combinationally
    assign dstOut = latchEnable ? srcIn : store_r; // [R3]
    assign dstOe  = !driveEnable_n;                // [R6] [R7]
    assign held   = store_r;
endmodule // rbt_path

/* design/rbt_top.sv */
// registered bus transceiver top: two directions, bus keepers, AXI4-Lite status/control
// assumes all pins synchronous to ref_clk; the bench resolves tri-state wires from enables
//
// Overview of operation
// [R1] move 18-bit data between A and B
// [R2] each direction has own enables and clock
// [R3] latch enable high passes data straight through
// [R4] latch enable low, steady clock holds value
// [R5] capture on falling capture clock edge
// [R6] drive enable low drives destination port
// [R7] drive enable high floats destination port
// [R8] clock gate input qualifies capture clock
// [R9] floating inputs keep last valid level
// [R10] B-to-A mirrors A-to-B with own controls
// [R11] clock gate high ignores clock edges
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
module rbt_top (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire logic [rbt_pkg::DATA_W-1:0] aPortIn,
    input  wire logic [rbt_pkg::DATA_W-1:0] aPortInDriven,
    output logic      [rbt_pkg::DATA_W-1:0] aPortOut,
    output logic                         aPortOe,
    input  wire logic [rbt_pkg::DATA_W-1:0] bPortIn,
    input  wire logic [rbt_pkg::DATA_W-1:0] bPortInDriven,
    output logic      [rbt_pkg::DATA_W-1:0] bPortOut,
    output logic                         bPortOe,
    input  wire logic                    aToBLatchEnable,
    input  wire logic                    aToBCaptureClock,
    input  wire logic                    aToBClockGate,
    input  wire logic                    aToBDriveEnable_n,
    input  wire logic                    bToALatchEnable,
    input  wire logic                    bToACaptureClock,
    input  wire logic                    bToAClockGate,
    input  wire logic                    bToADriveEnable_n,
    output logic      [rbt_pkg::DATA_W-1:0] capData,
    output logic                         capValid,
    input  wire logic                    capReady,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic      [1:0]              s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic      [31:0]             s_axi_rdata,
    output logic      [1:0]              s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    localparam int W = rbt_pkg::DATA_W;

    //--------------------------------------------------------------
    // bus keepers
    //--------------------------------------------------------------
    // undriven bits keep the last driven level so the logic never sees a float
    logic [W-1:0] aKeep_r, aKeep_nxt, bKeep_r, bKeep_nxt;
    logic [W-1:0] aSeen, bSeen;

    always_comb begin
        aKeep_nxt = aSeen; // [R9]
        bKeep_nxt = bSeen; // [R9]
    end
    assign aSeen = (aPortIn & aPortInDriven) | (aKeep_r & ~aPortInDriven); // [R9]
    assign bSeen = (bPortIn & bPortInDriven) | (bKeep_r & ~bPortInDriven); // [R9]

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            aKeep_r <= '0;
            bKeep_r <= '0;
        end else begin
            aKeep_r <= aKeep_nxt;
            bKeep_r <= bKeep_nxt;
        end
    end

    //--------------------------------------------------------------
    // control register, can override pins
    //--------------------------------------------------------------
    // effective control = pin OR register bit (clock gates and active-low drive enables: AND)
    logic [7:0] ctrl_r, ctrl_nxt;
    logic       abLe, abCk, abCg, abOe_n, baLe, baCk, baCg, baOe_n;

    assign abLe   = aToBLatchEnable   | ctrl_r[rbt_pkg::CTRL_AB_LE];
    assign abCk   = aToBCaptureClock  | ctrl_r[rbt_pkg::CTRL_AB_CK];
    assign abCg   = aToBClockGate     & ctrl_r[rbt_pkg::CTRL_AB_CG];
    assign abOe_n = aToBDriveEnable_n & ctrl_r[rbt_pkg::CTRL_AB_OE];
    assign baLe   = bToALatchEnable   | ctrl_r[rbt_pkg::CTRL_BA_LE];
    assign baCk   = bToACaptureClock  | ctrl_r[rbt_pkg::CTRL_BA_CK];
    assign baCg   = bToAClockGate     & ctrl_r[rbt_pkg::CTRL_BA_CG];
    assign baOe_n = bToADriveEnable_n & ctrl_r[rbt_pkg::CTRL_BA_OE];

    //--------------------------------------------------------------
    // the two directions
    //--------------------------------------------------------------
    logic [W-1:0] abHeld, baHeld;
    logic         abCap, baCap;

    rbt_path #(.W(W)) u_ab ( // [R1] [R2]
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .srcIn         (aSeen),
        .latchEnable   (abLe),
        .captureClock  (abCk),
        .clockGate     (abCg),
        .driveEnable_n (abOe_n),
        .dstOut        (bPortOut),
        .dstOe         (bPortOe),
        .held          (abHeld),
        .capturePulse  (abCap)
    );

    rbt_path #(.W(W)) u_ba ( // [R10]
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .srcIn         (bSeen),
        .latchEnable   (baLe),
        .captureClock  (baCk),
        .clockGate     (baCg),
        .driveEnable_n (baOe_n),
        .dstOut        (aPortOut),
        .dstOe         (aPortOe),
        .held          (baHeld),
        .capturePulse  (baCap)
    );

    //--------------------------------------------------------------
    // capture stream
    //--------------------------------------------------------------
    // every clocked A-to-B capture is also queued; a full queue drops the word
    // and counts it, since the pin clock cannot be stalled
    rbt_fifo_if #(.W(W)) capIn ();
    rbt_fifo_if #(.W(W)) capOut ();
    logic [7:0] dropCnt_r, dropCnt_nxt;

    assign capIn.valid  = abCap;
    assign capIn.data   = aSeen;
    assign capData      = capOut.data;
    assign capValid     = capOut.valid;
    assign capOut.ready = capReady;

    rbt_fifo #(.W(W), .D(rbt_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr      (capIn),
        .rd      (capOut)
    );

    always_comb begin
        dropCnt_nxt = dropCnt_r;
        if (abCap && !capIn.ready && dropCnt_r != 8'hFF) begin
            dropCnt_nxt = dropCnt_r + 8'h01;
        end
    end

    //--------------------------------------------------------------
    // AXI4-Lite slave
    //--------------------------------------------------------------
    logic        awHave_r, awHave_nxt, wHave_r, wHave_nxt;
    logic [7:0]  awAddr_r, awAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic [3:0]  wStrb_r, wStrb_nxt;
    logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
    logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
    logic [31:0] rData_r, rData_nxt;

    assign s_axi_awready = !awHave_r && !bValid_r;
    assign s_axi_wready  = !wHave_r && !bValid_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rresp   = rResp_r;
    assign s_axi_rdata   = rData_r;

    always_comb begin
        awHave_nxt = awHave_r;
        wHave_nxt  = wHave_r;
        awAddr_nxt = awAddr_r;
        wData_nxt  = wData_r;
        wStrb_nxt  = wStrb_r;
        bValid_nxt = bValid_r;
        bResp_nxt  = bResp_r;
        rValid_nxt = rValid_r;
        rResp_nxt  = rResp_r;
        rData_nxt  = rData_r;
        ctrl_nxt   = ctrl_r;
        if (s_axi_awvalid && s_axi_awready) begin
            awHave_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHave_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        if (awHave_r && wHave_r) begin
            awHave_nxt = 1'b0;
            wHave_nxt  = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt  = rbt_pkg::RESP_OKAY;
            if (awAddr_r == rbt_pkg::OFS_CTRL) begin
                if (wStrb_r[0]) begin
                    ctrl_nxt = wData_r[7:0];
                end
            end else if (awAddr_r == rbt_pkg::OFS_STATUS
                      || awAddr_r == rbt_pkg::OFS_AB_HOLD
                      || awAddr_r == rbt_pkg::OFS_BA_HOLD) begin
                bResp_nxt = rbt_pkg::RESP_OKAY;
            end else begin
                bResp_nxt = rbt_pkg::RESP_SLVERR;
            end
        end
        if (bValid_r && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rResp_nxt  = rbt_pkg::RESP_OKAY;
            case (s_axi_araddr)
                rbt_pkg::OFS_CTRL:    rData_nxt = {24'h00_0000, ctrl_r};
                rbt_pkg::OFS_STATUS:  rData_nxt = {16'h0000, dropCnt_r, 2'b00,
                                                   capValid, !capIn.ready,
                                                   !baOe_n, !abOe_n, baLe, abLe};
                rbt_pkg::OFS_AB_HOLD: rData_nxt = {14'h0000, abHeld};
                rbt_pkg::OFS_BA_HOLD: rData_nxt = {14'h0000, baHeld};
                default: begin
                    rData_nxt = 32'h0000_0000;
                    rResp_nxt = rbt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rValid_r && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            awHave_r  <= 1'b0;
            wHave_r   <= 1'b0;
            awAddr_r  <= 8'h00;
            wData_r   <= 32'h0000_0000;
            wStrb_r   <= 4'h0;
            bValid_r  <= 1'b0;
            bResp_r   <= rbt_pkg::RESP_OKAY;
            rValid_r  <= 1'b0;
            rResp_r   <= rbt_pkg::RESP_OKAY;
            rData_r   <= 32'h0000_0000;
            ctrl_r    <= rbt_pkg::CTRL_RESET;
            dropCnt_r <= 8'h00;
        end else begin
            awHave_r  <= awHave_nxt;
            wHave_r   <= wHave_nxt;
            awAddr_r  <= awAddr_nxt;
            wData_r   <= wData_nxt;
            wStrb_r   <= wStrb_nxt;
            bValid_r  <= bValid_nxt;
            bResp_r   <= bResp_nxt;
            rValid_r  <= rValid_nxt;
            rResp_r   <= rResp_nxt;
            rData_r   <= rData_nxt;
            ctrl_r    <= ctrl_nxt;
            dropCnt_r <= dropCnt_nxt;
        end
    end
endmodule // rbt_top

/* verif/rbt_bus_model.sv */
// far-side bus parties on the A and B ports, one wire level per bit
// assumes commands change just after ref_clk rising edges
module rbt_bus_model (
    input  wire logic        ref_clk,
    input  wire logic [17:0] aVal,
    input  wire logic [17:0] aMask,
    input  wire logic [17:0] bVal,
    input  wire logic [17:0] bMask,
    input  wire logic [17:0] aOut,
    input  wire logic        aOe,
    input  wire logic [17:0] bOut,
    input  wire logic        bOe,
    output logic      [17:0] aWire,
    output logic      [17:0] aDrv,
    output logic      [17:0] bWire,
    output logic      [17:0] bDrv
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [17:0] aLast_r;
    logic [17:0] bLast_r;
    // --------------------------------
    // wire resolution
    // --------------------------------
    always_ff @(posedge ref_clk) begin
        aLast_r <= (aVal & aMask) | (aLast_r & ~aMask);
        bLast_r <= (bVal & bMask) | (bLast_r & ~bMask);
    end
    // a released bit shows the inverse of its last level, so only a keeper hides it
    assign aWire = aOe ? aOut : ((aVal & aMask) | (~aLast_r & ~aMask));
    assign aDrv  = aOe ? '1 : aMask;
    assign bWire = bOe ? bOut : ((bVal & bMask) | (~bLast_r & ~bMask));
    assign bDrv  = bOe ? '1 : bMask;
endmodule // rbt_bus_model

/* verif/rbt_top_asserts.sv */
// pin-level checks of rbt_top, bound into every instance
// assumes ctrl override bits other than bit 0 keep their reset sense
module rbt_top_asserts (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [17:0] aPortIn,
    input wire logic [17:0] aPortInDriven,
    input wire logic [17:0] aPortOut,
    input wire logic        aPortOe,
    input wire logic [17:0] bPortIn,
    input wire logic [17:0] bPortInDriven,
    input wire logic [17:0] bPortOut,
    input wire logic        bPortOe,
    input wire logic        aToBLatchEnable,
    input wire logic        aToBCaptureClock,
    input wire logic        aToBClockGate,
    input wire logic        aToBDriveEnable_n,
    input wire logic        bToALatchEnable,
    input wire logic        bToACaptureClock,
    input wire logic        bToADriveEnable_n,
    input wire logic [17:0] capData,
    input wire logic        capValid,
    input wire logic        capReady,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // --------------------------------
    // properties
    // --------------------------------
    transp_ab_a: assert property (aToBLatchEnable && &aPortInDriven
        |-> bPortOut == aPortIn)
        else $error("b port not following a port");
    transp_ba_a: assert property (bToALatchEnable && &bPortInDriven
        |-> aPortOut == bPortIn)
        else $error("a port not following b port");
    // four steady samples leave room for a capture still in flight
    hold_ab_a: assert property ((!aToBLatchEnable && $stable(aToBCaptureClock))[*4]
        |-> $stable(bPortOut))
        else $error("held a to b value moved");
    hold_ba_a: assert property ((!bToALatchEnable && $stable(bToACaptureClock))[*4]
        |-> $stable(aPortOut))
        else $error("held b to a value moved");
    drive_ab_a: assert property (bPortOe == !aToBDriveEnable_n)
        else $error("b drive enable wrong");
    drive_ba_a: assert property (aPortOe == !bToADriveEnable_n)
        else $error("a drive enable wrong");
    push_ab_a: assert property ($fell(aToBCaptureClock) && !aToBLatchEnable
        && !aToBClockGate |-> ##[1:4] capValid)
        else $error("capture not queued");
    gate_ab_a: assert property (aToBClockGate[*6] ##0 !capValid |=> !capValid)
        else $error("gated clock still captured");
    fifo_hold_a: assert property (capValid && !capReady |=> capValid && $stable(capData))
        else $error("stalled capture word changed");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property ($fell(aToBCaptureClock) && !aToBClockGate);
    cover property ($fell(aToBCaptureClock) && aToBClockGate);
    cover property (capValid && !capReady);
endmodule // rbt_top_asserts

bind rbt_top rbt_top_asserts u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .aPortIn(aPortIn), .aPortInDriven(aPortInDriven),
    .aPortOut(aPortOut), .aPortOe(aPortOe), .bPortIn(bPortIn), .bPortInDriven(bPortInDriven),
    .bPortOut(bPortOut), .bPortOe(bPortOe), .aToBLatchEnable(aToBLatchEnable),
    .aToBCaptureClock(aToBCaptureClock), .aToBClockGate(aToBClockGate),
    .aToBDriveEnable_n(aToBDriveEnable_n), .bToALatchEnable(bToALatchEnable),
    .bToACaptureClock(bToACaptureClock), .bToADriveEnable_n(bToADriveEnable_n),
    .capData(capData), .capValid(capValid), .capReady(capReady),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

/* verif/rbt_top_tb_top.sv */
// self-checking bench for rbt_top with far-side bus model and AXI4-Lite master tasks
// assumes the checker binds itself from its own file
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errCount++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module rbt_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = '0;
    logic        rst_n = '0;
    logic [17:0] aVal, aMask, bVal, bMask, aPortIn, aDrv, bPortIn, bDrv, aPortOut, bPortOut;
    logic [17:0] capData;
    logic        aPortOe, bPortOe, capValid, capReady;
    logic        abLe, abCk, abCg, abOe_n, baLe, baCk, baCg, baOe_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          errCount = 0;
    int          checked = 0;
    int          cycles = 0;

    initial forever #2.5 ref_clk = ~ref_clk;

    rbt_bus_model u_bus (.ref_clk(ref_clk), .aVal(aVal), .aMask(aMask), .bVal(bVal),
        .bMask(bMask), .aOut(aPortOut), .aOe(aPortOe), .bOut(bPortOut), .bOe(bPortOe),
        .aWire(aPortIn), .aDrv(aDrv), .bWire(bPortIn), .bDrv(bDrv));
    rbt_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .aPortIn(aPortIn), .aPortInDriven(aDrv),
        .aPortOut(aPortOut), .aPortOe(aPortOe), .bPortIn(bPortIn), .bPortInDriven(bDrv),
        .bPortOut(bPortOut), .bPortOe(bPortOe), .aToBLatchEnable(abLe),
        .aToBCaptureClock(abCk), .aToBClockGate(abCg), .aToBDriveEnable_n(abOe_n),
        .bToALatchEnable(baLe), .bToACaptureClock(baCk), .bToAClockGate(baCg),
        .bToADriveEnable_n(baOe_n), .capData(capData), .capValid(capValid),
        .capReady(capReady), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // --------------------------------
    // bus and stream tasks
    // --------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= '1;
        wvalid <= '1;
        bready <= '1;
        pa = '1;
        pw = '1;
        while (pa || pw) begin
            @(negedge ref_clk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge ref_clk);
            if (ta) begin
                awvalid <= '0;
                pa = '0;
            end
            if (tw) begin
                wvalid <= '0;
                pw = '0;
            end
        end
        do @(negedge ref_clk); while (!bvalid);
        r = bresp;
        @(posedge ref_clk);
        bready <= '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= '1;
        rready <= '1;
        do @(negedge ref_clk); while (!arready);
        @(posedge ref_clk);
        arvalid <= '0;
        do @(negedge ref_clk); while (!rvalid);
        `CHK(rdata, e)
        `CHK(rresp, er)
        @(posedge ref_clk);
        rready <= '0;
    endtask
    // rising edge carries the complement, so a wrong-edge capture is caught
    task automatic cap_ab(input logic [17:0] d, input logic g);
        @(posedge ref_clk);
        abCg <= g;
        abCk <= '1;
        aVal <= ~d;
        wt(4);
        aVal <= d;
        wt(4);
        abCk <= '0;
        wt(4);
        aVal <= ~d;
        wt(4);
    endtask
    task automatic pop(input logic [17:0] e);
        do @(negedge ref_clk); while (!capValid);
        `CHK(capData, e)
        @(posedge ref_clk);
        capReady <= '1;
        @(posedge ref_clk);
        capReady <= '0;
    endtask

    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_regs;
        logic [1:0] r;
        rd_chk(rbt_pkg::OFS_CTRL, {24'h00_0000, rbt_pkg::CTRL_RESET}, rbt_pkg::RESP_OKAY);
        rd_chk(8'h10, 32'h0000_0000, rbt_pkg::RESP_SLVERR);
        axi_wr(rbt_pkg::OFS_STATUS, 32'h0000_FFFF, r);
        `CHK(r, rbt_pkg::RESP_OKAY)
        axi_wr(8'h10, 32'h0000_0001, r);
        `CHK(r, rbt_pkg::RESP_SLVERR)
        axi_wr(rbt_pkg::OFS_CTRL, 32'h0000_00CD, r);
        rd_chk(rbt_pkg::OFS_CTRL, 32'h0000_00CD, rbt_pkg::RESP_OKAY);
        rd_chk(rbt_pkg::OFS_STATUS, 32'h0000_0001, rbt_pkg::RESP_OKAY);
        axi_wr(rbt_pkg::OFS_CTRL, 32'h0000_00CC, r);
    endtask
    task automatic t_transp;
        abLe <= '1;
        abOe_n <= '0;
        aVal <= 18'h2_5A3C;
        wt(2);
        @(negedge ref_clk);
        `CHK(bPortOut, 18'h2_5A3C)
        `CHK(bPortOe, '1)
        @(posedge ref_clk);
        abLe <= '0;
        abOe_n <= '1;
        baLe <= '1;
        baOe_n <= '0;
        bVal <= 18'h1_C3A5;
        wt(2);
        @(negedge ref_clk);
        `CHK(aPortOut, 18'h1_C3A5)
        `CHK(bPortOe, '0)
        `CHK(bPortOut, 18'h2_5A3C)
    endtask
    task automatic t_keep;
        @(posedge ref_clk);
        baLe <= '0;
        baOe_n <= '1;
        abLe <= '1;
        aVal <= 18'h0_0F0F;
        wt(2);
        aMask <= 18'h3_FF00;
        aVal <= 18'h3_F0F0;
        wt(2);
        @(negedge ref_clk);
        `CHK(bPortOut, 18'h3_F00F)
        @(posedge ref_clk);
        aMask <= '1;
        abLe <= '0;
    endtask
    task automatic t_cap;
        cap_ab(18'h1_2345, '0);
        @(negedge ref_clk);
        `CHK(bPortOut, 18'h1_2345)
        rd_chk(rbt_pkg::OFS_AB_HOLD, 32'h0001_2345, rbt_pkg::RESP_OKAY);
        pop(18'h1_2345);
        cap_ab(18'h0_0ABC, '1);
        @(negedge ref_clk);
        `CHK(bPortOut, 18'h1_2345)
        `CHK(capValid, '0)
        // clocked capture in the other direction
        @(posedge ref_clk);
        baCg <= '0;
        baCk <= '1;
        bVal <= 18'h2_0F0F;
        wt(2);
        baCk <= '0;
        wt(2);
        bVal <= '0;
        rd_chk(rbt_pkg::OFS_BA_HOLD, 32'h0002_0F0F, rbt_pkg::RESP_OKAY);
    endtask
    task automatic t_fifo;
        for (int i = 0; i < 5; i++) cap_ab(18'h0_1000 + 18'(i), '0);
        rd_chk(rbt_pkg::OFS_STATUS, 32'h0000_0130, rbt_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) pop(18'h0_1000 + 18'(i));
        @(negedge ref_clk);
        `CHK(capValid, '0)
    endtask

    task automatic summarize;
        if (errCount == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            summarize();
        end
    end

    initial begin
        {aVal, bVal, abLe, abCk, abCg, baLe, baCk, capReady} = '0;
        {aMask, bMask, abOe_n, baOe_n, baCg} = '1;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wt(12);
        rst_n <= '1;
        t_regs();
        t_transp();
        t_keep();
        t_cap();
        t_fifo();
        summarize();
    end
endmodule // rbt_top_tb_top
